// *** hdl/cell_array.sv ***
// One frame of storage cells in flip-flops, column-major layout.
// Assumes writes and reads never target the same frame at once.
`timescale 1ns/1ps
`include "interleave_defines.svh"
module cell_array
   import interleave_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic mclk, // System clock
   input wire logic wr_en, // Write strobe, already clock enabled
   input wire logic [9:0] wr_addr, // Cell written
   input wire logic [W-1:0] wr_data, // Value written
   input wire logic [9:0] rd_addr, // Cell read
   output logic [W-1:0] rd_data // Value at rd_addr
);
   logic [W-1:0] mem_ff [`FRAME_CELLS];

   // Cell write by index
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem_ff[wr_addr] <= wr_data;
      end
   end

   // Read selection
   assign rd_data = mem_ff[rd_addr];
endmodule // cell_array

// *** hdl/interleave_defines.svh ***
// Constants for the reverse channel block interleaver and deinterleaver.
// Assumes one 40 MHz clock; included by the package and every design module.
// How it works
// [RULE1] Interleaver array is 32 rows by 18 columns
// [RULE2] Fill by columns, output only once full
// [RULE3] Full rate reads rows in natural order
// [RULE4] Half rate swaps middle rows of fours
// [RULE5] Quarter rate reads eights as 1,5,2,6...
// [RULE6] Eighth rate reads sixteens as 1,9,2,10...
// [RULE7] Source repeats symbols to fill whole frame
// [RULE8] Each 576 input group is one frame
// [RULE9] Deinterleaver array is 18 rows by 32 columns
// [RULE10] Deinterleaver fills completely before any output
// [RULE11] Deinterleaver emits stored samples row by row
// [RULE12] Deinterleaver takes and gives 576 per frame
// [RULE13] Deinterleaver exactly undoes same rate interleaver
// [RULE14] Deinterleaver source gives combined soft samples
// [RULE15] Interleaver source gives reverse traffic symbols
// [RULE16] Low rates read columns by inverse row order
// [RULE17] Rate held from first symbol to frame end
`ifndef INTERLEAVE_DEFINES_SVH
`define INTERLEAVE_DEFINES_SVH
`define CELL_LAST 10'h23f
`define IL_ROW_LAST 5'h1f
`define IL_COL_LAST 5'h11
`define DL_ROW_LAST 5'h11
`define DL_COL_LAST 5'h1f
`define DL_ROWS 10'h012
`define SOFT_W 8
`define FIFO_DEPTH 16
`define FRAME_CELLS 576
`endif

// *** hdl/interleave_pkg.sv ***
// Types and row order function shared by the interleaver design.
// Assumes the defines header is on the include path.
`include "interleave_defines.svh"
package interleave_pkg;
   // Frame rate of the traffic channel
   typedef enum logic [1:0] {
      RATE_FULL = 2'h0,
      RATE_HALF = 2'h1,
      RATE_QUARTER = 2'h2,
      RATE_EIGHTH = 2'h3
   } rate_t;

   // Frame engine states, Gray along fill to drain
   typedef enum logic [1:0] {
      ST_FILL = 2'h0,
      ST_DRAIN = 2'h1
   } frame_state_t;

   // Code symbol with end of frame marker
   typedef struct packed {
      logic last;
      logic sym;
   } code_word_t;

   // Soft sample with end of frame marker
   typedef struct packed {
      logic last;
      logic [`SOFT_W-1:0] smp;
   } soft_word_t;

   // Row order of the read pass; inv gives the inverse order
   function automatic logic [4:0] row_map(rate_t r, logic [4:0] i, logic inv);
      logic [4:0] m;
      m = i;
      case (r)
         RATE_HALF: m = {i[4:2], i[0], i[1]};
         RATE_QUARTER: m = inv ? {i[4:3], i[1:0], i[2]} : {i[4:3], i[0], i[2:1]};
         RATE_EIGHTH: m = inv ? {i[4], i[2:0], i[3]} : {i[4], i[0], i[3:1]};
         default: m = i;
      endcase
      return m;
   endfunction
endpackage

// *** hdl/reverse_block_interleaver.sv ***
// Reverse channel block interleaver and deinterleaver, one frame each.
// Assumes synchronous valid/ready streams and rate held per frame.
`timescale 1ns/1ps
`include "interleave_defines.svh"
module reverse_block_interleaver
   import interleave_pkg::*;
(
   input wire logic mclk, // 40 MHz clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   input wire logic il_in_valid, // Code symbol offered
   input wire logic il_in_sym, // Code symbol
   input wire rate_t il_rate, // Interleaver rate, with first symbol
   output logic il_in_ready, // Interleaver filling
   output logic il_out_valid, // Interleaved symbol ready
   output code_word_t il_out, // Interleaved symbol and frame end
   input wire logic il_out_ready, // Downstream takes symbol
   input wire logic dl_in_valid, // Soft sample offered
   input wire logic [`SOFT_W-1:0] dl_in_smp, // Soft sample
   input wire rate_t dl_rate, // Deinterleaver rate, with first sample
   output logic dl_in_ready, // Deinterleaver filling
   output logic dl_out_valid, // Deinterleaved sample ready
   output soft_word_t dl_out, // Deinterleaved sample and frame end
   input wire logic dl_out_ready // Decoder takes sample
);
   // Interleaver engine state
   frame_state_t il_st_ff, nxt_il_st;
   rate_t il_rate_ff, nxt_il_rate;
   logic [9:0] il_wcnt_ff, nxt_il_wcnt;
   logic [4:0] il_rrow_ff, nxt_il_rrow;
   logic [4:0] il_col_ff, nxt_il_col;
   logic il_in_ready_ff;
   logic [9:0] il_ocnt_ff;
   logic il_fifo_ready;
   logic il_rd_data;
   code_word_t il_fifo_in;

   // Interleaver decode
   wire il_take = ce & il_in_valid & il_in_ready_ff;
   wire il_wr_last = (il_wcnt_ff == `CELL_LAST);
   wire il_fifo_valid = (il_st_ff == ST_DRAIN);
   wire il_push = ce & il_fifo_valid & il_fifo_ready;
   wire il_col_end = (il_col_ff == `IL_COL_LAST);
   wire il_frame_end = il_col_end & (il_rrow_ff == `IL_ROW_LAST);
   wire [4:0] il_phys = row_map(il_rate_ff, il_rrow_ff, 1'b0); // RULE3 RULE4 RULE5 RULE6
   wire [9:0] il_rd_addr = {il_col_ff, il_phys}; // RULE1
   assign il_fifo_in = '{last: il_frame_end, sym: il_rd_data};
   assign il_in_ready = il_in_ready_ff;

   // Interleaver next state
   always_comb begin
      nxt_il_st = il_st_ff;
      nxt_il_rate = il_rate_ff;
      nxt_il_wcnt = il_wcnt_ff;
      nxt_il_rrow = il_rrow_ff;
      nxt_il_col = il_col_ff;
      case (il_st_ff)
         ST_FILL: begin
            if (il_take) begin
               if (il_wcnt_ff == 10'h000) nxt_il_rate = il_rate; // RULE17
               nxt_il_wcnt = il_wr_last ? 10'h000 : il_wcnt_ff + 10'h001; // RULE2
               if (il_wr_last) nxt_il_st = ST_DRAIN; // RULE2 RULE8
            end
         end
         ST_DRAIN: begin
            if (il_push) begin
               nxt_il_col = il_col_end ? 5'h00 : il_col_ff + 5'h01;
               if (il_col_end) nxt_il_rrow = il_rrow_ff + 5'h01;
               if (il_frame_end) nxt_il_st = ST_FILL; // RULE8
            end
         end
         default: nxt_il_st = ST_FILL;
      endcase
   end

   // Interleaver registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         il_st_ff <= ST_FILL;
         il_rate_ff <= RATE_FULL;
         il_wcnt_ff <= 10'h000;
         il_rrow_ff <= 5'h00;
         il_col_ff <= 5'h00;
         il_in_ready_ff <= 1'b1;
      end else if (ce) begin
         il_st_ff <= nxt_il_st;
         il_rate_ff <= nxt_il_rate;
         il_wcnt_ff <= nxt_il_wcnt;
         il_rrow_ff <= nxt_il_rrow;
         il_col_ff <= nxt_il_col;
         il_in_ready_ff <= (nxt_il_st == ST_FILL);
      end
   end

   // Interleaver storage, 32 rows by 18 columns
   cell_array #(.W(1)) u_il_cells (
      .mclk(mclk),
      .wr_en(il_take),
      .wr_addr(il_wcnt_ff),
      .wr_data(il_in_sym),
      .rd_addr(il_rd_addr),
      .rd_data(il_rd_data)
   );

   // Interleaver output buffer
   sym_fifo #(.W($bits(code_word_t)), .DEPTH(`FIFO_DEPTH)) u_il_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(il_fifo_valid),
      .in_ready(il_fifo_ready),
      .in_data(il_fifo_in),
      .out_valid(il_out_valid),
      .out_ready(il_out_ready),
      .out_data(il_out)
   );

   // Deinterleaver engine state
   frame_state_t dl_st_ff, nxt_dl_st;
   rate_t dl_rate_ff, nxt_dl_rate;
   logic [9:0] dl_wcnt_ff, nxt_dl_wcnt;
   logic [4:0] dl_k_ff, nxt_dl_k;
   logic [4:0] dl_p_ff, nxt_dl_p;
   logic dl_in_ready_ff;
   logic [9:0] dl_ocnt_ff;
   logic dl_fifo_ready;
   logic [`SOFT_W-1:0] dl_rd_data;
   soft_word_t dl_fifo_in;

   // Deinterleaver decode
   wire dl_take = ce & dl_in_valid & dl_in_ready_ff; // RULE14
   wire dl_wr_last = (dl_wcnt_ff == `CELL_LAST);
   wire dl_fifo_valid = (dl_st_ff == ST_DRAIN);
   wire dl_push = ce & dl_fifo_valid & dl_fifo_ready;
   wire dl_p_end = (dl_p_ff == `DL_COL_LAST);
   wire dl_frame_end = dl_p_end & (dl_k_ff == `DL_ROW_LAST);
   wire [4:0] dl_pcol = row_map(dl_rate_ff, dl_p_ff, 1'b1); // RULE13 RULE16
   wire [9:0] dl_col_base = 10'({5'h00, dl_pcol} * `DL_ROWS);
   wire [9:0] dl_rd_addr = dl_col_base + {5'h00, dl_k_ff}; // RULE9 RULE11
   assign dl_fifo_in = '{last: dl_frame_end, smp: dl_rd_data};
   assign dl_in_ready = dl_in_ready_ff;

   // Deinterleaver next state
   always_comb begin
      nxt_dl_st = dl_st_ff;
      nxt_dl_rate = dl_rate_ff;
      nxt_dl_wcnt = dl_wcnt_ff;
      nxt_dl_k = dl_k_ff;
      nxt_dl_p = dl_p_ff;
      case (dl_st_ff)
         ST_FILL: begin
            if (dl_take) begin
               if (dl_wcnt_ff == 10'h000) nxt_dl_rate = dl_rate; // RULE17
               nxt_dl_wcnt = dl_wr_last ? 10'h000 : dl_wcnt_ff + 10'h001; // RULE10
               if (dl_wr_last) nxt_dl_st = ST_DRAIN; // RULE10 RULE12
            end
         end
         ST_DRAIN: begin
            if (dl_push) begin
               nxt_dl_p = dl_p_end ? 5'h00 : dl_p_ff + 5'h01; // RULE11
               if (dl_p_end) nxt_dl_k = dl_frame_end ? 5'h00 : dl_k_ff + 5'h01; // RULE11 RULE12
               if (dl_frame_end) nxt_dl_st = ST_FILL; // RULE12
            end
         end
         default: nxt_dl_st = ST_FILL;
      endcase
   end

   // Deinterleaver registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dl_st_ff <= ST_FILL;
         dl_rate_ff <= RATE_FULL;
         dl_wcnt_ff <= 10'h000;
         dl_k_ff <= 5'h00;
         dl_p_ff <= 5'h00;
         dl_in_ready_ff <= 1'b1;
      end else if (ce) begin
         dl_st_ff <= nxt_dl_st;
         dl_rate_ff <= nxt_dl_rate;
         dl_wcnt_ff <= nxt_dl_wcnt;
         dl_k_ff <= nxt_dl_k;
         dl_p_ff <= nxt_dl_p;
         dl_in_ready_ff <= (nxt_dl_st == ST_FILL);
      end
   end

   // Deinterleaver storage, 18 rows by 32 columns
   cell_array #(.W(`SOFT_W)) u_dl_cells (
      .mclk(mclk),
      .wr_en(dl_take),
      .wr_addr(dl_wcnt_ff),
      .wr_data(dl_in_smp),
      .rd_addr(dl_rd_addr),
      .rd_data(dl_rd_data)
   );

   // Deinterleaver output buffer
   sym_fifo #(.W($bits(soft_word_t)), .DEPTH(`FIFO_DEPTH)) u_dl_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(dl_fifo_valid),
      .in_ready(dl_fifo_ready),
      .in_data(dl_fifo_in),
      .out_valid(dl_out_valid),
      .out_ready(dl_out_ready),
      .out_data(dl_out)
   );

   // Output counters seen only by the checks
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         il_ocnt_ff <= 10'h000;
         dl_ocnt_ff <= 10'h000;
      end else begin
         if (il_push) il_ocnt_ff <= il_frame_end ? 10'h000 : il_ocnt_ff + 10'h001;
         if (dl_push) dl_ocnt_ff <= dl_frame_end ? 10'h000 : dl_ocnt_ff + 10'h001;
      end
   end

   // Checks on the frame engines
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   il_cell_range_a: assert property (il_push |-> il_rd_addr <= `CELL_LAST) // RULE1
      else $error("interleaver read outside the array");
   il_fill_first_a: assert property ( // RULE2
      il_st_ff == ST_DRAIN && $past(il_st_ff) == ST_FILL |-> $past(il_wcnt_ff) == `CELL_LAST)
      else $error("interleaver drained before array full");
   il_full_order_a: assert property (il_push && il_rate_ff == RATE_FULL |-> il_phys == il_rrow_ff) // RULE3
      else $error("full rate row order wrong");
   il_half_order_a: assert property (il_push && il_rate_ff == RATE_HALF // RULE4
      |-> il_phys == {il_rrow_ff[4:2], il_rrow_ff[0], il_rrow_ff[1]})
      else $error("half rate row order wrong");
   il_quarter_order_a: assert property (il_push && il_rate_ff == RATE_QUARTER // RULE5
      |-> il_phys == {il_rrow_ff[4:3], il_rrow_ff[0], il_rrow_ff[2:1]})
      else $error("quarter rate row order wrong");
   il_eighth_order_a: assert property (il_push && il_rate_ff == RATE_EIGHTH // RULE6
      |-> il_phys == {il_rrow_ff[4], il_rrow_ff[0], il_rrow_ff[3:1]})
      else $error("eighth rate row order wrong");
   il_frame_len_a: assert property (il_push && il_frame_end |-> il_ocnt_ff == `CELL_LAST) // RULE8
      else $error("interleaver frame not 576 symbols");
   il_rate_hold_a: assert property (il_st_ff == ST_DRAIN |=> $stable(il_rate_ff)) // RULE17
      else $error("interleaver rate changed mid frame");
   dl_cell_range_a: assert property (dl_push |-> dl_rd_addr <= `CELL_LAST) // RULE9
      else $error("deinterleaver read outside the array");
   dl_fill_first_a: assert property ( // RULE10
      dl_st_ff == ST_DRAIN && $past(dl_st_ff) == ST_FILL |-> $past(dl_wcnt_ff) == `CELL_LAST)
      else $error("deinterleaver drained before array full");
   dl_row_step_a: assert property (dl_push && dl_p_end && !dl_frame_end // RULE11
      |=> dl_k_ff == $past(dl_k_ff) + 5'h01 && dl_p_ff == 5'h00)
      else $error("deinterleaver row walk wrong");
   dl_frame_len_a: assert property (dl_push && dl_frame_end |-> dl_ocnt_ff == `CELL_LAST) // RULE12
      else $error("deinterleaver frame not 576 samples");
   dl_inverse_a: assert property (dl_push |-> row_map(dl_rate_ff, dl_pcol, 1'b0) == dl_p_ff) // RULE16
      else $error("deinterleaver column order not inverse");
   dl_rate_hold_a: assert property (dl_st_ff == ST_DRAIN |=> $stable(dl_rate_ff)) // RULE17
      else $error("deinterleaver rate changed mid frame");

   // Handshake, walk and restart checks
   il_ready_state_a: assert property (il_in_ready == (il_st_ff == ST_FILL)) // RULE2
      else $error("interleaver input ready outside fill");
   dl_ready_state_a: assert property (dl_in_ready == (dl_st_ff == ST_FILL)) // RULE10
      else $error("deinterleaver input ready outside fill");
   il_wr_range_a: assert property (il_take |-> il_wcnt_ff <= `CELL_LAST) // RULE2
      else $error("interleaver write outside the array");
   il_col_step_a: assert property (il_push && !il_col_end // RULE3
      |=> il_col_ff == $past(il_col_ff) + 5'h01 && $stable(il_rrow_ff))
      else $error("interleaver column walk wrong");
   dl_col_step_a: assert property (dl_push && !dl_p_end // RULE11
      |=> dl_p_ff == $past(dl_p_ff) + 5'h01 && $stable(dl_k_ff))
      else $error("deinterleaver column walk wrong");
   il_wrap_a: assert property (il_push && il_frame_end // RULE8
      |=> il_col_ff == 5'h00 && il_rrow_ff == 5'h00 && il_st_ff == ST_FILL)
      else $error("interleaver did not restart at first cell");
   dl_wrap_a: assert property (dl_push && dl_frame_end // RULE12
      |=> dl_k_ff == 5'h00 && dl_p_ff == 5'h00 && dl_st_ff == ST_FILL)
      else $error("deinterleaver did not restart at first cell");
   il_rate_take_a: assert property (il_take && il_wcnt_ff == 10'h000 // RULE17
      |=> il_rate_ff == $past(il_rate))
      else $error("interleaver rate not taken with first symbol");
   dl_rate_take_a: assert property (dl_take && dl_wcnt_ff == 10'h000 // RULE17
      |=> dl_rate_ff == $past(dl_rate))
      else $error("deinterleaver rate not taken with first sample");
   il_out_hold_a: assert property (il_out_valid && !(ce && il_out_ready) // RULE8
      |=> il_out_valid && $stable(il_out))
      else $error("interleaver output lost before taken");
   dl_out_hold_a: assert property (dl_out_valid && !(ce && dl_out_ready) // RULE12
      |=> dl_out_valid && $stable(dl_out))
      else $error("deinterleaver output lost before taken");
   il_last_mark_a: assert property (il_push // RULE8
      |-> il_fifo_in.last == (il_ocnt_ff == `CELL_LAST))
      else $error("interleaver frame end mark misplaced");
   dl_last_mark_a: assert property (dl_push // RULE12
      |-> dl_fifo_in.last == (dl_ocnt_ff == `CELL_LAST))
      else $error("deinterleaver frame end mark misplaced");

   // Main scenarios
   il_eighth_frame_c: cover property (il_push && il_frame_end && il_rate_ff == RATE_EIGHTH);
   dl_quarter_frame_c: cover property (dl_push && dl_frame_end && dl_rate_ff == RATE_QUARTER);
   il_fifo_stall_c: cover property (il_fifo_valid && !il_fifo_ready);
   dl_fifo_stall_c: cover property (dl_fifo_valid && !dl_fifo_ready);
   dl_back_to_back_c: cover property (dl_push && dl_frame_end ##1 dl_take);
endmodule // reverse_block_interleaver

// *** hdl/sym_fifo.sv ***
// Small FIFO with registered output stage between engine and consumer.
// Assumes the consumer may hold out_ready low for any length of time.
`timescale 1ns/1ps
`include "interleave_defines.svh"
module sym_fifo
   import interleave_pkg::*;
#(
   parameter int W = 1,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic mclk, // System clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic ce, // Clock enable, freezes state when low
   input wire logic in_valid, // Producer has a word
   output logic in_ready, // Room for a word
   input wire logic [W-1:0] in_data, // Word in
   output logic out_valid, // Output register holds a word
   input wire logic out_ready, // Consumer takes the word
   output logic [W-1:0] out_data // Word out
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};
   logic [W-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ptr_ff, rd_ptr_ff;
   logic out_valid_ff;
   logic [W-1:0] out_data_ff;
   wire empty = (wr_ptr_ff == rd_ptr_ff);
   wire full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
   wire do_wr = ce & in_valid & ~full;
   wire do_rd = ce & ~empty & (~out_valid_ff | out_ready);

   // Handshake outputs
   assign in_ready = ~full;
   assign out_valid = out_valid_ff;
   assign out_data = out_data_ff;

   // Storage write
   always_ff @(posedge mclk) begin
      if (do_wr) begin
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
      end
   end

   // Pointers and output stage
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         out_valid_ff <= 1'b0;
         out_data_ff <= '0;
      end else if (ce) begin
         if (do_wr) wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
         if (do_rd) begin
            rd_ptr_ff <= rd_ptr_ff + PTR_ONE;
            out_data_ff <= mem_ff[rd_ptr_ff[AW-1:0]];
            out_valid_ff <= 1'b1;
         end else if (out_ready) begin
            out_valid_ff <= 1'b0;
         end
      end
   end
endmodule // sym_fifo

// *** verification/stream_sink.sv ***
// Downstream sink model that drives ready with a chosen stall pattern.
// Assumes the bench changes the mode only between frames.
`timescale 1ns/1ps
module stream_sink (
   input wire logic mclk, // System clock
   input wire logic [1:0] mode, // 0 always, 1 one in three, 2 long stalls
   output logic ready // Ready toward the block
);
   int cnt;
   initial begin
      cnt = 0;
      ready = 1'b1;
   end
   // Ready moves just after the falling edge, away from sampling
   always @(negedge mclk) begin
      cnt <= cnt + 1;
      case (mode)
         2'h1: ready <= (cnt % 3 == 0);
         2'h2: ready <= ((cnt / 40) % 2 == 1); // Long stalls fill the FIFO
         default: ready <= 1'b1;
      endcase
   end
endmodule // stream_sink

// *** verification/tb_top.sv ***
// Self-checking bench for the reverse block interleaver and deinterleaver.
// Assumes the design files and stream_sink are compiled before it.
`timescale 1ns/1ps
module tb_top
   import interleave_pkg::*;
;
   localparam int LIMIT = 40000;
   logic mclk, rst_n, ce, ce_gap;
   logic il_in_valid, il_in_sym, il_in_ready, il_out_valid, il_out_ready;
   logic dl_in_valid, dl_in_ready, dl_out_valid, dl_out_ready;
   logic [7:0] dl_in_smp;
   logic [1:0] sink_mode;
   rate_t il_rate, dl_rate;
   code_word_t il_out;
   soft_word_t dl_out;
   int n_errors, checks_done, cyc;

   reverse_block_interleaver dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
      .il_in_valid(il_in_valid), .il_in_sym(il_in_sym), .il_rate(il_rate),
      .il_in_ready(il_in_ready), .il_out_valid(il_out_valid), .il_out(il_out),
      .il_out_ready(il_out_ready), .dl_in_valid(dl_in_valid), .dl_in_smp(dl_in_smp),
      .dl_rate(dl_rate), .dl_in_ready(dl_in_ready), .dl_out_valid(dl_out_valid),
      .dl_out(dl_out), .dl_out_ready(dl_out_ready));
   stream_sink il_sink (.mclk(mclk), .mode(sink_mode), .ready(il_out_ready));
   stream_sink dl_sink (.mclk(mclk), .mode(sink_mode), .ready(dl_out_ready));

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Clock enable gaps, one cycle in five when asked for
   always @(negedge mclk) ce <= ce_gap ? (cyc % 5 != 0) : 1'b1;
   // Hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_errors++;
         $display("ERROR %0t timeout", $time);
         tally_and_finish();
      end
   end

   // Row read order of the interleaver, from the documented lists
   function automatic int perm(int rt, int r);
      int g, j;
      g = 2 << rt;
      j = r % g;
      if (rt == 0) return r;
      return r - j + (j % 2) * (g / 2) + j / 2;
   endfunction
   // Input index that the interleaver emits in output slot j
   function automatic int il_src(int rt, int j);
      return (j % 18) * 32 + perm(rt, j / 18);
   endfunction
   function automatic logic sym_of(int n);
      int t;
      t = (n * 7) ^ (n / 5) ^ (n / 33);
      return t[2];
   endfunction
   function automatic logic [7:0] smp_of(int n);
      return 8'(n * 37 + n / 256);
   endfunction

   task automatic chk_bit(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   task automatic chk_code(input code_word_t got, input code_word_t exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_soft(input soft_word_t got, input soft_word_t exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One whole frame through one path; poke moves the rate after word 0
   task automatic frame(input bit dl, input int rt, input bit poke);
      int i, k;
      bit tk, fed;
      logic exp_b [576];
      logic [7:0] exp_s [576];
      logic [7:0] in_s [576];
      for (int j = 0; j < 576; j++) begin
         exp_b[j] = sym_of(il_src(rt, j));
         in_s[j] = smp_of(il_src(rt, j));
         exp_s[j] = smp_of(j);
      end
      i = 0;
      k = 0;
      fed = 0;
      fork
         begin
            while (i < 576) begin
               @(negedge mclk);
               il_in_valid <= !dl;
               dl_in_valid <= dl;
               il_in_sym <= sym_of(i);
               dl_in_smp <= in_s[i];
               il_rate <= rate_t'(2'(rt + (poke && i > 0)));
               dl_rate <= rate_t'(2'(rt + (poke && i > 0)));
               #1;
               tk = ce & (dl ? dl_in_ready : il_in_ready);
               @(posedge mclk);
               if (tk) i++;
            end
            fed = 1;
            // Junk offered while the block refuses input
            repeat (8) begin
               @(negedge mclk);
               il_in_sym <= ~il_in_sym;
               dl_in_smp <= 8'hff;
               if (dl ? dl_in_ready : il_in_ready) begin
                  il_in_valid <= 1'b0;
                  dl_in_valid <= 1'b0;
               end
            end
            @(negedge mclk);
            il_in_valid <= 1'b0;
            dl_in_valid <= 1'b0;
         end
         begin
            while (k < 576) begin
               @(negedge mclk);
               #1;
               if (!fed) chk_bit(dl ? dl_out_valid : il_out_valid, 1'b0, "early out");
               else if (ce && (dl ? dl_out_valid && dl_out_ready : il_out_valid && il_out_ready)) begin
                  if (dl) chk_soft(dl_out, {k == 575, exp_s[k]}, "deinterleaved");
                  else chk_code(il_out, {k == 575, exp_b[k]}, "interleaved");
                  k++;
               end
            end
         end
      join
      repeat (3) @(negedge mclk);
      chk_bit(dl ? dl_out_valid : il_out_valid, 1'b0, "extra out");
      chk_bit(dl ? dl_in_ready : il_in_ready, 1'b1, "ready again");
   endtask

   task automatic t_reset;
      @(negedge mclk);
      chk_bit(il_in_ready, 1'b1, "il ready");
      chk_bit(dl_in_ready, 1'b1, "dl ready");
      chk_bit(il_out_valid, 1'b0, "il valid");
      chk_bit(dl_out_valid, 1'b0, "dl valid");
      $display("test reset done, errors %0d", n_errors);
   endtask
   task automatic t_il_rates;
      for (int rt = 0; rt < 4; rt++) frame(0, rt, 0);
      $display("test interleaver rates done, errors %0d", n_errors);
   endtask
   task automatic t_dl_rates;
      for (int rt = 0; rt < 4; rt++) frame(1, rt, 0);
      $display("test deinterleaver rates done, errors %0d", n_errors);
   endtask
   task automatic t_stall;
      sink_mode = 2'h1;
      ce_gap = 1'b1;
      frame(0, 2, 0);
      sink_mode = 2'h2;
      frame(1, 3, 0);
      frame(0, 0, 0);
      ce_gap = 1'b0;
      sink_mode = 2'h0;
      $display("test back pressure done, errors %0d", n_errors);
   endtask
   task automatic t_rate_hold;
      frame(0, 1, 1);
      frame(1, 2, 1);
      $display("test rate hold done, errors %0d", n_errors);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      ce_gap = 1'b0;
      il_in_valid = 1'b0;
      il_in_sym = 1'b0;
      dl_in_valid = 1'b0;
      dl_in_smp = 8'h00;
      il_rate = RATE_FULL;
      dl_rate = RATE_FULL;
      sink_mode = 2'h0;
      n_errors = 0;
      checks_done = 0;
      cyc = 0;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_il_rates();
      t_dl_rates();
      t_stall();
      t_rate_hold();
      tally_and_finish();
   end
endmodule // tb_top
